// file: cold_load_detect.sv
// cold load pick-up detector with AXI4-Lite settings and status
// Operation
// - only fundamental magnitudes of the three phases are measured
// - each phase magnitude is compared against each of the three threshold settings continuously
// - picked comparisons release below 97 percent of the setting
// - one setting value serves all three phases
// - overcurrent picks up when any one phase exceeds, inrush only when all three phases exceed
// - setting group may switch while running, new values apply at once
// - low condition needs all phases below low threshold, default 0.20
// - inrush needs all phases above high threshold, default 1.20
// - any phase above overcurrent threshold releases activation at once
// - status shows normal, low, overcurrent, active or blocked
// - activation after low condition lasts the start time, zero is immediate
// - maximum timer runs during inrush, expiry releases activation
// - minimum timer holds activation between thresholds, then releases
// - block active at pick-up gives blocked output and stops processing
`default_nettype none
module cold_load_detect #(
    parameter int TICK_CYCLES = cold_load_pkg::TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [cold_load_pkg::MEAS_W-1:0] phase_a_fundamental,
    input wire logic [cold_load_pkg::MEAS_W-1:0] phase_b_fundamental,
    input wire logic [cold_load_pkg::MEAS_W-1:0] phase_c_fundamental,
    input wire logic block_in,
    output logic cold_load_active_out,
    output logic blocked_out,
    output logic [2:0] cold_load_condition_status,
    output logic irq,
    input wire logic [cold_load_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cold_load_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int NG = cold_load_pkg::NUM_GROUPS;
    localparam int NS = cold_load_pkg::NUM_SET;
    localparam int SW = cold_load_pkg::SET_W;
    localparam int EW = cold_load_pkg::EV_W;
    localparam int AW = cold_load_pkg::ADDR_W;
    localparam int BANK_IDX_HI = cold_load_pkg::BANK_GROUP_BIT - 1;

    typedef struct packed {
        cold_load_pkg::fsm_t st;
        logic [cold_load_pkg::TIMER_W-1:0] timer;
        logic [31:0] div;
        logic tick;
        logic [2:0] blk_sync;
        logic block_level;
        logic group;
        logic [NG-1:0][NS-1:0][SW-1:0] cfg;
        logic [EW-1:0] events;
        logic [EW-1:0] mask;
        logic irq;
        logic active;
        logic blocked;
        cold_load_pkg::cond_t cond;
        logic aw_got;
        logic w_got;
        logic [AW-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } regs_t;

    regs_t r;
    regs_t n;
    logic [NS-1:0][SW-1:0] cfg_cur;
    logic [cold_load_pkg::NUM_PHASES-1:0][cold_load_pkg::MEAS_W-1:0] meas;
    logic [cold_load_pkg::NUM_THR-1:0][cold_load_pkg::NUM_PHASES-1:0] above;
    logic low_cond;
    logic high_all;
    logic over_any;
    logic pick;

    assign cfg_cur = r.cfg[r.group];
    assign meas = {phase_c_fundamental, phase_b_fundamental, phase_a_fundamental};

    for (genvar k = 0; k < cold_load_pkg::NUM_THR; k++) begin : g_thr
        for (genvar p = 0; p < cold_load_pkg::NUM_PHASES; p++) begin : g_ph
            threshold_hysteresis #(
                .MEAS_W(cold_load_pkg::MEAS_W),
                .THR_W(SW)
            ) u_cmp (
                .mclk(mclk),
                .srst(srst),
                .meas(meas[p]),
                .thr(cfg_cur[k]),
                .picked(above[k][p])
            );
        end
    end

    assign low_cond = ~|above[cold_load_pkg::SET_LOW];
    assign high_all = &above[cold_load_pkg::SET_HIGH];
    assign over_any = |above[cold_load_pkg::SET_OVER];

    assign cold_load_active_out = r.active;
    assign blocked_out = r.blocked;
    assign cold_load_condition_status = r.cond;
    assign irq = r.irq;
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic bank_hit(input logic [AW-1:0] a);
        logic [AW-1:0] off;
        off = AW'(a - cold_load_pkg::BANK_BASE);
        return a >= cold_load_pkg::BANK_BASE && a < cold_load_pkg::BANK_END &&
               32'(off[BANK_IDX_HI:cold_load_pkg::BANK_IDX_LSB]) < NS;
    endfunction

    always_comb begin
        logic [EW-1:0] ev_set;
        logic [EW-1:0] ev_clr;
        logic [AW-1:0] off;
        logic [31:0] rd;
        n = r;
        ev_set = '0;
        ev_clr = '0;
        off = '0;
        rd = '0;
        pick = 1'b0;
        n.tick = 1'b0;

        // 5 ms tick from the program clock
        if (r.div >= 32'(TICK_CYCLES - 1)) begin
            n.div = '0;
            n.tick = 1'b1;
        end else begin
            n.div = r.div + 32'h1;
        end

        // block pin: level changes once stages two and three agree
        n.blk_sync = {r.blk_sync[1:0], block_in};
        if (r.blk_sync[1] == r.blk_sync[2]) begin
            n.block_level = r.blk_sync[2];
        end

        case (r.st)
            cold_load_pkg::ST_NORMAL: begin
                if (low_cond) begin
                    n.st = cold_load_pkg::ST_LOW;
                    ev_set[cold_load_pkg::EV_LOW_START] = 1'b1;
                end
            end
            cold_load_pkg::ST_LOW: begin
                if (!low_cond) begin
                    n.st = cold_load_pkg::ST_NORMAL;
                end else if (r.timer >= cfg_cur[cold_load_pkg::SET_TSET]) begin
                    pick = 1'b1;
                end else if (r.tick) begin
                    n.timer = r.timer + 1'b1;
                end
            end
            cold_load_pkg::ST_ARMED, cold_load_pkg::ST_MIN, cold_load_pkg::ST_MAX: begin
                if (over_any) begin
                    n.st = cold_load_pkg::ST_OVER;
                    ev_set[cold_load_pkg::EV_OVER] = 1'b1;
                end else if (r.block_level) begin
                    n.st = cold_load_pkg::ST_NORMAL;
                end else if (r.st == cold_load_pkg::ST_MAX) begin
                    if (!high_all) begin
                        n.st = cold_load_pkg::ST_MIN;
                    end else if (r.timer >= cfg_cur[cold_load_pkg::SET_TMAX]) begin
                        n.st = cold_load_pkg::ST_NORMAL;
                    end else if (r.tick) begin
                        n.timer = r.timer + 1'b1;
                    end
                end else if (high_all) begin
                    n.st = cold_load_pkg::ST_MAX;
                    ev_set[cold_load_pkg::EV_HIGH_START] = 1'b1;
                end else if (low_cond) begin
                    n.st = cold_load_pkg::ST_ARMED;
                end else if (r.st == cold_load_pkg::ST_ARMED) begin
                    n.st = cold_load_pkg::ST_MIN;
                end else if (r.timer >= cfg_cur[cold_load_pkg::SET_TMIN]) begin
                    n.st = cold_load_pkg::ST_NORMAL;
                end else if (r.tick) begin
                    n.timer = r.timer + 1'b1;
                end
            end
            cold_load_pkg::ST_OVER: begin
                if (!over_any) begin
                    n.st = cold_load_pkg::ST_NORMAL;
                end
            end
            cold_load_pkg::ST_BLOCKED: begin
                if (!r.block_level) begin
                    n.st = cold_load_pkg::ST_NORMAL;
                end
            end
            default: begin
                n.st = cold_load_pkg::ST_NORMAL;
            end
        endcase

        if (pick) begin
            if (r.block_level) begin
                n.st = cold_load_pkg::ST_BLOCKED;
                ev_set[cold_load_pkg::EV_BLOCKED] = 1'b1;
            end else begin
                n.st = cold_load_pkg::ST_ARMED;
                ev_set[cold_load_pkg::EV_ACT_ON] = 1'b1;
            end
        end

        // timer restarts on every state change
        if (n.st != r.st) begin
            n.timer = '0;
        end

        n.active = n.st == cold_load_pkg::ST_ARMED || n.st == cold_load_pkg::ST_MIN ||
                   n.st == cold_load_pkg::ST_MAX;
        n.blocked = n.st == cold_load_pkg::ST_BLOCKED;
        if (r.active && !n.active) begin
            ev_set[cold_load_pkg::EV_ACT_OFF] = 1'b1;
        end
        case (n.st)
            cold_load_pkg::ST_NORMAL: n.cond = cold_load_pkg::COND_NORMAL;
            cold_load_pkg::ST_LOW: n.cond = cold_load_pkg::COND_LOW;
            cold_load_pkg::ST_OVER: n.cond = cold_load_pkg::COND_OVER;
            cold_load_pkg::ST_BLOCKED: n.cond = cold_load_pkg::COND_BLOCKED;
            default: n.cond = cold_load_pkg::COND_ACTIVE;
        endcase

        // write channel: address and data taken in either order
        if (r.awready && s_axi_awvalid) begin
            n.aw_got = 1'b1;
            n.waddr = s_axi_awaddr;
        end
        if (r.wready && s_axi_wvalid) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = cold_load_pkg::RESP_OKAY;
            off = AW'(r.waddr - cold_load_pkg::BANK_BASE);
            if (r.waddr == cold_load_pkg::CTRL_ADDR) begin
                if (r.wstrb[0]) begin
                    n.group = r.wdata[cold_load_pkg::CTRL_GROUP];
                end
            end else if (r.waddr == cold_load_pkg::MASK_ADDR) begin
                n.mask = EW'(strb_merge(32'(r.mask), r.wdata, r.wstrb));
            end else if (bank_hit(r.waddr)) begin
                n.cfg[off[cold_load_pkg::BANK_GROUP_BIT]][off[BANK_IDX_HI:cold_load_pkg::BANK_IDX_LSB]] =
                    SW'(strb_merge(32'(r.cfg[off[cold_load_pkg::BANK_GROUP_BIT]]
                        [off[BANK_IDX_HI:cold_load_pkg::BANK_IDX_LSB]]), r.wdata, r.wstrb));
            end else if (r.waddr != cold_load_pkg::STATUS_ADDR && r.waddr != cold_load_pkg::EVENT_ADDR) begin
                n.bresp = cold_load_pkg::RESP_SLVERR;
            end
        end

        // read channel
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (r.arready && s_axi_arvalid) begin
            n.rvalid = 1'b1;
            n.rresp = cold_load_pkg::RESP_OKAY;
            off = AW'(s_axi_araddr - cold_load_pkg::BANK_BASE);
            if (s_axi_araddr == cold_load_pkg::CTRL_ADDR) begin
                rd[cold_load_pkg::CTRL_GROUP] = r.group;
            end else if (s_axi_araddr == cold_load_pkg::STATUS_ADDR) begin
                rd[cold_load_pkg::STS_COND_LSB +: 3] = r.cond;
                rd[cold_load_pkg::STS_ACTIVE] = r.active;
                rd[cold_load_pkg::STS_BLOCKED] = r.blocked;
                rd[cold_load_pkg::STS_LOW] = low_cond;
                rd[cold_load_pkg::STS_HIGH] = high_all;
                rd[cold_load_pkg::STS_OVER] = over_any;
                rd[cold_load_pkg::STS_BLOCK_IN] = r.block_level;
                rd[cold_load_pkg::STS_GROUP] = r.group;
            end else if (s_axi_araddr == cold_load_pkg::EVENT_ADDR) begin
                rd = 32'(r.events);
                ev_clr = r.events;
            end else if (s_axi_araddr == cold_load_pkg::MASK_ADDR) begin
                rd = 32'(r.mask);
            end else if (bank_hit(s_axi_araddr)) begin
                rd = 32'(r.cfg[off[cold_load_pkg::BANK_GROUP_BIT]][off[BANK_IDX_HI:cold_load_pkg::BANK_IDX_LSB]]);
            end else begin
                n.rresp = cold_load_pkg::RESP_SLVERR;
            end
            n.rdata = rd;
        end

        // a new event in the clearing read's cycle survives
        n.events = (r.events & ~ev_clr) | ev_set;
        n.irq = |(n.events & n.mask);
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;

        if (srst) begin
            n = '0;
            n.cfg = {NG{cold_load_pkg::SET_RESET}};
        end
    end

    always_ff @(posedge mclk) begin
        r <= n;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    sequence pickup_s;
        r.st == cold_load_pkg::ST_LOW && low_cond && r.timer >= cfg_cur[cold_load_pkg::SET_TSET];
    endsequence

    sequence max_expiry_s;
        r.st == cold_load_pkg::ST_MAX && high_all && !over_any && !r.block_level &&
        r.timer >= cfg_cur[cold_load_pkg::SET_TMAX];
    endsequence

    over_release_a: assert property (cold_load_active_out && over_any |=>
        !cold_load_active_out && cold_load_condition_status == cold_load_pkg::COND_OVER)
        else $error("overcurrent did not release activation");
    block_pickup_a: assert property (pickup_s and r.block_level |=> blocked_out && !cold_load_active_out)
        else $error("blocked pick-up not reported");
    pickup_act_a: assert property (pickup_s and !r.block_level |=> cold_load_active_out ##1
        (cold_load_active_out || $past(over_any) || $past(r.block_level) || $past(high_all) || !$past(low_cond)))
        else $error("activation missing after start time");
    low_entry_a: assert property (r.st == cold_load_pkg::ST_NORMAL && !low_cond |=>
        r.st != cold_load_pkg::ST_LOW)
        else $error("low state entered without all phases low");
    max_entry_a: assert property ($rose(r.st == cold_load_pkg::ST_MAX) |-> $past(high_all))
        else $error("inrush timer started without all phases high");
    max_expire_a: assert property (max_expiry_s |=> !cold_load_active_out)
        else $error("activation held past maximum time");
    min_hold_a: assert property (r.st == cold_load_pkg::ST_MIN && !over_any && !high_all && !low_cond &&
        !r.block_level && r.timer < cfg_cur[cold_load_pkg::SET_TMIN] |=> cold_load_active_out)
        else $error("activation dropped before minimum time");
    timer_restart_a: assert property ($changed(r.st) |-> r.timer == '0)
        else $error("timer not restarted on state change");
    status_range_a: assert property (cold_load_condition_status <= cold_load_pkg::COND_BLOCKED &&
        (cold_load_active_out == (cold_load_condition_status == cold_load_pkg::COND_ACTIVE)))
        else $error("condition status out of range or inconsistent");
endmodule
`default_nettype wire

// file: cold_load_pkg.sv
// constants and types shared by the cold load detector
`default_nettype none
package cold_load_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 5_000_000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int MEAS_W = 16;
    localparam int SET_W = 20;
    localparam int TIMER_W = 20;
    localparam int ADDR_W = 8;
    localparam int NUM_PHASES = 3;
    localparam int NUM_THR = 3;
    localparam int NUM_GROUPS = 2;
    localparam int NUM_SET = 6;
    localparam int HYST_PCT = 97;
    localparam int FULL_PCT = 100;

    // setting slots within a group, thresholds first
    localparam int SET_LOW = 0;
    localparam int SET_HIGH = 1;
    localparam int SET_OVER = 2;
    localparam int SET_TSET = 3;
    localparam int SET_TMAX = 4;
    localparam int SET_TMIN = 5;

    // thresholds in 0.01 x nominal, timers in 5 ms ticks
    localparam logic [SET_W-1:0] LOW_RST = 20'h00014;
    localparam logic [SET_W-1:0] HIGH_RST = 20'h00078;
    localparam logic [SET_W-1:0] OVER_RST = 20'h000C8;
    localparam logic [SET_W-1:0] TSET_RST = 20'h007D0;
    localparam logic [SET_W-1:0] TMAX_RST = 20'h01770;
    localparam logic [SET_W-1:0] TMIN_RST = 20'h00008;
    localparam logic [NUM_SET-1:0][SET_W-1:0] SET_RESET = {TMIN_RST, TMAX_RST, TSET_RST, OVER_RST, HIGH_RST, LOW_RST};

    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] EVENT_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] BANK_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] BANK_END = 8'h60;
    localparam int BANK_GROUP_BIT = 5;
    localparam int BANK_IDX_LSB = 2;

    localparam int CTRL_GROUP = 0;
    localparam int STS_COND_LSB = 0;
    localparam int STS_ACTIVE = 3;
    localparam int STS_BLOCKED = 4;
    localparam int STS_LOW = 5;
    localparam int STS_HIGH = 6;
    localparam int STS_OVER = 7;
    localparam int STS_BLOCK_IN = 8;
    localparam int STS_GROUP = 9;

    localparam int EV_W = 6;
    localparam int EV_ACT_ON = 0;
    localparam int EV_ACT_OFF = 1;
    localparam int EV_BLOCKED = 2;
    localparam int EV_LOW_START = 3;
    localparam int EV_HIGH_START = 4;
    localparam int EV_OVER = 5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0,
        COND_LOW = 3'h1,
        COND_OVER = 3'h2,
        COND_ACTIVE = 3'h3,
        COND_BLOCKED = 3'h4
    } cond_t;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'h0,
        ST_LOW = 3'h1,
        ST_ARMED = 3'h2,
        ST_MIN = 3'h3,
        ST_MAX = 3'h4,
        ST_OVER = 3'h5,
        ST_BLOCKED = 3'h6
    } fsm_t;
endpackage
`default_nettype wire

// file: threshold_hysteresis.sv
// one magnitude against one threshold, with release at 97 percent of the threshold
`default_nettype none
module threshold_hysteresis #(
    parameter int MEAS_W = 16,
    parameter int THR_W = 20
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [MEAS_W-1:0] meas,
    input wire logic [THR_W-1:0] thr,
    output logic picked
);
    localparam int PW = ((MEAS_W > THR_W) ? MEAS_W : THR_W) + 8;

    typedef struct packed {
        logic picked;
    } cmp_t;

    cmp_t r;
    cmp_t n;
    logic [PW-1:0] meas_x;
    logic [PW-1:0] thr_x;
    logic [PW-1:0] meas_pct;
    logic [PW-1:0] thr_hyst;

    assign meas_x = PW'(meas);
    assign thr_x = PW'(thr);
    // scaling both sides avoids a divider while keeping the ratio exact
    assign meas_pct = PW'(meas_x * PW'(cold_load_pkg::FULL_PCT));
    assign thr_hyst = PW'(thr_x * PW'(cold_load_pkg::HYST_PCT));
    assign picked = r.picked;

    always_comb begin
        n = r;
        if (srst) begin
            n = '0;
        end else if (meas_x > thr_x) begin
            n.picked = 1'b1;
        end else if (meas_pct < thr_hyst) begin
            n.picked = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        r <= n;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    pick_up_a: assert property (meas_x > thr_x |=> picked)
        else $error("comparison did not pick up above threshold");
    hyst_hold_a: assert property (picked && meas_pct >= thr_hyst |=> picked)
        else $error("comparison released inside the hysteresis band");
    release_a: assert property (meas_pct < thr_hyst |=> !picked)
        else $error("comparison held below 97 percent of threshold");
endmodule
`default_nettype wire

// file: meas_path.sv
// measurement path model: three fundamental magnitudes in a chosen current band
`default_nettype none
module meas_path (
    input wire logic mclk,
    input wire logic [1:0] band,
    output logic [15:0] a = 16'h0000,
    output logic [15:0] b = 16'h0000,
    output logic [15:0] c = 16'h0000
);
    timeunit 1ns;
    timeprecision 100ps;
    // bands sit clear of each threshold and of its 97 percent release point
    int lo[4] = '{0, 30, 130, 130};
    function automatic logic [15:0] pick(input logic [1:0] s);
        return 16'(lo[s] + $urandom % 16);
    endfunction
    always @(posedge mclk) begin
        a <= band == 2'h3 ? 16'h00FA : pick(band);
        b <= pick(band);
        c <= pick(band);
    end
endmodule
`default_nettype wire

// file: cold_load_detect_tb.sv
// self-checking bench for the cold load detector
`default_nettype none
module cold_load_detect_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic block_in = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [15:0] phase_a_fundamental, phase_b_fundamental, phase_c_fundamental;
    logic cold_load_active_out, blocked_out, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    // start between thresholds so no start timer runs during register setup
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, band = 2'h1;
    logic [2:0] cold_load_condition_status;
    int fail_count = 0;
    int comparisons = 0;
    int set_m[2][6];
    cold_load_detect #(.TICK_CYCLES(4)) i_dut (.*);
    meas_path i_meas (.mclk, .band, .a(phase_a_fundamental), .b(phase_b_fundamental), .c(phase_c_fundamental));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic test_done;
        $display("counts: %0d compared, %0d failed", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic lim(input int n);
        chk("timeout", 32'(n >= 999), 32'h0);
        if (n >= 999) test_done;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 999);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        lim(n);
    endtask
    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 999);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        lim(n);
    endtask
    task automatic setg(input int g, input int i, input int v);
        set_m[g][i] = v;
        wr(8'(32 + 32 * g + 4 * i), 32'(v));
        chk("write resp", 32'(resp), 32'(cold_load_pkg::RESP_OKAY));
    endtask
    task automatic chkset;
        for (int g = 0; g < 2; g++) begin
            for (int i = 0; i < 6; i++) begin
                rdr(8'(32 + 32 * g + 4 * i));
                chk("setting", rd, 32'(set_m[g][i]));
                chk("read resp", 32'(resp), 32'(cold_load_pkg::RESP_OKAY));
            end
        end
    endtask
    // waits a bounded time for {blocked, active} to reach v
    task automatic wt(input logic [1:0] v, input int m);
        int n;
        n = 0;
        while ({blocked_out, cold_load_active_out} !== v && n < m) begin
            @(posedge mclk);
            n++;
        end
        chk("outputs", 32'({blocked_out, cold_load_active_out}), 32'(v));
    endtask
    initial begin
        void'($urandom(34308));
        foreach (set_m[g, i]) set_m[g][i] = int'(cold_load_pkg::SET_RESET[i]);
        repeat (5) @(posedge mclk);
        srst <= 1'h0;
        chkset();
        rdr(8'h10);
        chk("unmapped read", 32'(resp), 32'(cold_load_pkg::RESP_SLVERR));
        wr(8'h10, 32'h0);
        chk("unmapped write", 32'(resp), 32'(cold_load_pkg::RESP_SLVERR));
        setg(0, cold_load_pkg::SET_TSET, 10);
        setg(0, cold_load_pkg::SET_TMIN, 10);
        setg(0, cold_load_pkg::SET_TMAX, 10);
        setg(1, cold_load_pkg::SET_TSET, 0);
        chkset();
        wr(cold_load_pkg::MASK_ADDR, 32'h3F);
        rdr(cold_load_pkg::MASK_ADDR);
        chk("mask", rd, 32'h3F);
        // the comparators leave reset as not picked, so a low start event is already pending
        rdr(cold_load_pkg::EVENT_ADDR);
        $display("registers done");
        band <= 2'h0;
        repeat (6) @(posedge mclk);
        chk("status", 32'(cold_load_condition_status), 32'(cold_load_pkg::COND_LOW));
        repeat (14) @(posedge mclk);
        wt(2'h0, 0);
        wt(2'h1, 99);
        chk("status", 32'(cold_load_condition_status), 32'(cold_load_pkg::COND_ACTIVE));
        chk("irq", 32'(irq), 32'h1);
        rdr(cold_load_pkg::EVENT_ADDR);
        chk("events", rd & 32'h9, 32'h9);
        repeat (3) @(posedge mclk);
        chk("irq", 32'(irq), 32'h0);
        $display("start timer done");
        band <= 2'h1;
        repeat (8) @(posedge mclk);
        wt(2'h1, 0);
        wt(2'h0, 99);
        band <= 2'h0;
        wt(2'h1, 99);
        band <= 2'h2;
        repeat (8) @(posedge mclk);
        wt(2'h1, 0);
        wt(2'h0, 99);
        $display("min and max timers done");
        band <= 2'h0;
        wt(2'h1, 99);
        band <= 2'h3;
        wt(2'h0, 6);
        repeat (2) @(posedge mclk);
        chk("status", 32'(cold_load_condition_status), 32'(cold_load_pkg::COND_OVER));
        $display("overcurrent done");
        wr(cold_load_pkg::CTRL_ADDR, 32'h1);
        band <= 2'h0;
        wt(2'h1, 20);
        rdr(cold_load_pkg::CTRL_ADDR);
        chk("group", rd, 32'h1);
        $display("group switch done");
        // block raised while active ends the activation, then blocks the next pick-up
        block_in <= 1'h1;
        wt(2'h2, 30);
        chk("status", 32'(cold_load_condition_status), 32'(cold_load_pkg::COND_BLOCKED));
        rdr(cold_load_pkg::STATUS_ADDR);
        chk("status reg", rd, 32'h334);
        rdr(cold_load_pkg::EVENT_ADDR);
        chk("events", rd, 32'h3F);
        $display("block done");
        test_done();
    end
endmodule
`default_nettype wire
